// >>> hdl/pamr_pkg.sv
// constants and types shared by the transceiver mode and status register block
package pamr_pkg;
  localparam int unsigned CLK_FREQ_HZ = 20_000_000;
  localparam int unsigned JABBER_TIME_MS = 20;
  localparam int unsigned BLINK_TIME_MS = 40;
  localparam int unsigned JABBER_CYCLES_DEF = JABBER_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned BLINK_CYCLES_DEF = BLINK_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam logic [4:0] PHY_ADDR_DEF = 5'h01;
  // register offsets
  localparam logic [4:0] REG_AUX_MODE_TWO = 5'h1B;
  localparam logic [4:0] REG_ERR_GEN_STATUS = 5'h1C;
  // auxiliary_mode_two layout
  localparam logic [15:0] AUX2_RESET = 16'h000A;
  localparam logic [15:0] AUX2_WMASK = 16'h0EFE;
  localparam int AUX2_LED_MODE = 9;
  localparam int AUX2_ECHO_BLOCK = 7;
  localparam int AUX2_SQE_CTL = 3;
  // tenbase_error_general_status layout
  localparam logic [15:0] ERRST_RESET = 16'h0800;
  localparam logic [15:0] ERRST_WMASK = 16'hD800;
  localparam logic [7:0] ERRST_RO_LOW = 8'h27;
  localparam int ERR_MDIX_STATUS = 13;
  localparam int ERR_MDIX_FORCE = 12;
  localparam int ERR_AUTO_DIS = 11;
  localparam int ERR_JABBER = 9;
  localparam int ERR_POLARITY = 8;
  // management frame fields
  localparam logic [3:0] MDIO_PRE_START = 4'hD;
  localparam logic [1:0] MDIO_OP_READ = 2'h2;
  localparam logic [1:0] MDIO_OP_WRITE = 2'h1;
  localparam logic [4:0] MDIO_RD_BITS = 5'h10;
  localparam logic [4:0] MDIO_WR_LAST = 5'h11;
  typedef enum logic [3:0] {
    MS_HUNT = 4'h1,
    MS_TURN = 4'h2,
    MS_READ = 4'h4,
    MS_WRITE = 4'h8
  } pamr_mdio_state_t;
endpackage

// >>> hdl/pamr_mdio_slave.sv
// serial management slave: frame decode, register strobes, read data shift-out
`timescale 1ns/1ps
module pamr_mdio_slave #(
  parameter logic [4:0] PHY_ADDR = pamr_pkg::PHY_ADDR_DEF
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // management pins
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  // register port
  output logic [4:0] reg_addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [15:0] wr_data_o,
  input wire logic [15:0] rd_data_i
);
  import pamr_pkg::*;
  logic mdc_d;
  logic mdc_rise;
  logic [15:0] sr;
  logic [15:0] next_sr;
  logic [15:0] shout;
  logic [4:0] cnt;
  pamr_mdio_state_t state;

  assign mdc_rise = mdc_i & ~mdc_d;
  assign next_sr = {sr[14:0], mdio_i};

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      mdc_d <= 1'b0;
    end else begin
      mdc_d <= mdc_i;
    end
  end

  // frame sequencer, one step per mdc rising edge
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state <= MS_HUNT;
      sr <= 16'h0000;
      shout <= 16'h0000;
      cnt <= 5'h00;
      reg_addr_o <= 5'h00;
      rd_o <= 1'b0;
      wr_o <= 1'b0;
      wr_data_o <= 16'h0000;
      mdio_o <= 1'b0;
      mdio_oe_o <= 1'b0;
    end else begin
      rd_o <= 1'b0;
      wr_o <= 1'b0;
      if (mdc_rise) begin
        case (state)
          MS_HUNT: begin
            sr <= next_sr;
            if (next_sr[15:12] == MDIO_PRE_START && next_sr[9:5] == PHY_ADDR) begin
              reg_addr_o <= next_sr[4:0];
              cnt <= 5'h00;
              if (next_sr[11:10] == MDIO_OP_READ) begin
                rd_o <= 1'b1;
                state <= MS_TURN;
              end else if (next_sr[11:10] == MDIO_OP_WRITE) begin
                state <= MS_WRITE;
              end
            end
          end
          MS_TURN: begin
            mdio_oe_o <= 1'b1;
            mdio_o <= 1'b0;
            shout <= rd_data_i;
            cnt <= MDIO_RD_BITS;
            state <= MS_READ;
          end
          MS_READ: begin
            if (cnt == 5'h00) begin
              mdio_oe_o <= 1'b0;
              mdio_o <= 1'b0;
              sr <= 16'h0000;
              state <= MS_HUNT;
            end else begin
              mdio_o <= shout[15];
              shout <= {shout[14:0], 1'b0};
              cnt <= cnt - 5'h01;
            end
          end
          MS_WRITE: begin
            sr <= next_sr;
            cnt <= cnt + 5'h01;
            if (cnt == MDIO_WR_LAST) begin
              wr_o <= 1'b1;
              wr_data_o <= next_sr;
              sr <= 16'h0000;
              state <= MS_HUNT;
            end
          end
          default: begin
            state <= MS_HUNT;
          end
        endcase
      end
    end
  end
endmodule

// >>> hdl/pamr_led_drive.sv
// indicator driver: steady and blinking patterns for link, speed and activity
`timescale 1ns/1ps
module pamr_led_drive #(
  parameter int unsigned BLINK_CYCLES = pamr_pkg::BLINK_CYCLES_DEF
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // line state
  input wire logic led_mode_i,
  input wire logic link_up_i,
  input wire logic speed100_i,
  input wire logic full_duplex_i,
  input wire logic activity_i,
  input wire logic collision_i,
  // indicators
  output logic led_link_o,
  output logic led_speed_o,
  output logic led_act_o
);
  import pamr_pkg::*;
  localparam int W = $clog2(BLINK_CYCLES + 1);
  localparam logic [W-1:0] HALF = W'(BLINK_CYCLES / 2);
  localparam logic [W-1:0] FULL = W'(BLINK_CYCLES);
  logic [W-1:0] cnt [2];
  logic [1:0] ev;

  // dark in the first half of a blink, lit in the second
  function automatic logic blink_lit(input logic [W-1:0] c);
    blink_lit = (c != '0) && (c <= HALF);
  endfunction

  function automatic logic blink_dark(input logic [W-1:0] c);
    blink_dark = c > HALF;
  endfunction

  assign ev = {collision_i, activity_i};

  // one blink engine per event source
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      for (int k = 0; k < 2; k++) begin
        cnt[k] <= '0;
      end
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (cnt[k] != '0) begin
          cnt[k] <= cnt[k] - W'(1);
        end else if (ev[k]) begin
          cnt[k] <= FULL;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      led_link_o <= 1'b0;
      led_speed_o <= 1'b0;
      led_act_o <= 1'b0;
    end else begin
      led_speed_o <= speed100_i;
      if (led_mode_i) begin
        led_link_o <= link_up_i & ~blink_dark(cnt[0]); // RULE1
        led_act_o <= full_duplex_i ? ~blink_dark(cnt[1]) : blink_lit(cnt[1]); // RULE1
      end else begin
        led_link_o <= link_up_i; // RULE2
        led_act_o <= blink_lit(cnt[0]); // RULE2
      end
    end
  end

  property p_led_speed;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    1'b1 |=> led_speed_o == $past(speed100_i);
  endproperty
  a_led_speed: assert property (p_led_speed) else $error("speed indicator wrong"); // RULE2

  property p_led_link_steady;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (!led_mode_i && link_up_i) |=> led_link_o;
  endproperty
  a_led_link_steady: assert property (p_led_link_steady) else $error("link not lit"); // RULE2

  property p_led_link_down;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    !link_up_i |=> !led_link_o;
  endproperty
  a_led_link_down: assert property (p_led_link_down) else $error("link lit while down"); // RULE1
endmodule

// >>> hdl/pamr_mode_status.sv
// auxiliary mode two and error/general status registers with their mode logic
// How it works
// RULE1: mode one: link blinks, act shows duplex/collision
// RULE2: mode zero: link steady, activity indicator blinks
// RULE3: echo block stops transmit echo on rx_dv
// RULE4: echo block: crs follows tx_en, drops immediately
// RULE5: sqe bit zero forces sqe in 10 half
// RULE6: status bit shows crossed pair assignment
// RULE7: force bit selects crossed pairs unless fiber
// RULE8: auto crossover result used when neither forced nor disabled
// RULE9: disable bit resets one, stops auto crossover
// RULE10: jabber flag latches, clears on read when gone
// RULE11: jabber zero at 100, shared with other registers
// RULE12: polarity flag shows a polarity change occurred
// RULE13: long transmit in 10Base-T shuts transmitter off
// RULE14: reserved fields keep reset values or hold writes
`timescale 1ns/1ps
module pamr_mode_status #(
  parameter int unsigned JABBER_CYCLES = pamr_pkg::JABBER_CYCLES_DEF,
  parameter int unsigned BLINK_CYCLES = pamr_pkg::BLINK_CYCLES_DEF,
  parameter logic [4:0] PHY_ADDR = pamr_pkg::PHY_ADDR_DEF
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // management pins
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  // line mode
  input wire logic speed100_i,
  input wire logic full_duplex_i,
  input wire logic fiber_mode_select_i,
  input wire logic link_up_i,
  // mac side
  input wire logic tx_en_i,
  input wire logic rx_dv_raw_i,
  input wire logic crs_raw_i,
  output logic rx_dv_o,
  output logic crs_o,
  // transmitter
  input wire logic jabber_disable_i,
  output logic tx_shutoff_o,
  output logic sqe_force_o,
  // crossover
  input wire logic auto_mdix_sel_i,
  output logic mdix_auto_en_o,
  output logic mdix_sel_o,
  // events
  input wire logic activity_i,
  input wire logic collision_i,
  input wire logic polarity_event_i,
  input wire logic status_mirror_rd_i,
  output logic jabber_flag_o,
  // indicators
  output logic led_link_o,
  output logic led_speed_o,
  output logic led_act_o
);
  import pamr_pkg::*;
  localparam int JW = $clog2(JABBER_CYCLES + 1);
  localparam logic [JW-1:0] JAB_LAST = JW'(JABBER_CYCLES - 1);

  logic [4:0] reg_addr;
  logic rd;
  logic wr;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  logic [15:0] next_rd_data;
  logic [15:0] aux2;
  logic [15:0] errctl;
  logic polarity_flag;
  logic [JW-1:0] jab_cnt;
  logic tx_seen;
  logic ten_hd;
  logic echo_blk;
  logic rd_errst;

  function automatic logic reg_hit(input logic [4:0] addr, input logic [4:0] off);
    reg_hit = (addr == off);
  endfunction

  assign ten_hd = ~speed100_i & ~full_duplex_i;
  assign echo_blk = aux2[AUX2_ECHO_BLOCK] & ten_hd;
  assign rd_errst = rd & reg_hit(reg_addr, REG_ERR_GEN_STATUS);

  pamr_mdio_slave #(
    .PHY_ADDR(PHY_ADDR)
  ) u_mdio (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .mdc_i(mdc_i),
    .mdio_i(mdio_i),
    .mdio_o(mdio_o),
    .mdio_oe_o(mdio_oe_o),
    .reg_addr_o(reg_addr),
    .rd_o(rd),
    .wr_o(wr),
    .wr_data_o(wr_data),
    .rd_data_i(rd_data)
  );

  pamr_led_drive #(
    .BLINK_CYCLES(BLINK_CYCLES)
  ) u_led (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .led_mode_i(aux2[AUX2_LED_MODE]),
    .link_up_i(link_up_i),
    .speed100_i(speed100_i),
    .full_duplex_i(full_duplex_i),
    .activity_i(activity_i),
    .collision_i(collision_i),
    .led_link_o(led_link_o),
    .led_speed_o(led_speed_o),
    .led_act_o(led_act_o)
  );

  // writable fields; read-only bits keep their reset values
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      aux2 <= AUX2_RESET;
      errctl <= ERRST_RESET; // RULE9
    end else if (wr) begin
      if (reg_hit(reg_addr, REG_AUX_MODE_TWO)) begin
        aux2 <= (wr_data & AUX2_WMASK) | (AUX2_RESET & ~AUX2_WMASK); // RULE14
      end
      if (reg_hit(reg_addr, REG_ERR_GEN_STATUS)) begin
        errctl <= wr_data & ERRST_WMASK; // RULE14
      end
    end
  end

  // read value assembly
  always_comb begin
    next_rd_data = 16'h0000;
    if (reg_hit(reg_addr, REG_AUX_MODE_TWO)) begin
      next_rd_data = aux2;
    end else if (reg_hit(reg_addr, REG_ERR_GEN_STATUS)) begin
      next_rd_data = errctl;
      next_rd_data[7:0] = ERRST_RO_LOW; // RULE14
      next_rd_data[ERR_MDIX_STATUS] = mdix_sel_o; // RULE6
      next_rd_data[ERR_JABBER] = jabber_flag_o; // RULE11
      next_rd_data[ERR_POLARITY] = polarity_flag; // RULE12
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      rd_data <= 16'h0000;
    end else if (rd) begin
      rd_data <= next_rd_data;
    end
  end

  // jabber timer
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      jab_cnt <= '0;
      tx_shutoff_o <= 1'b0;
    end else if (!tx_en_i || speed100_i || jabber_disable_i) begin
      jab_cnt <= '0;
      tx_shutoff_o <= 1'b0; // RULE13
    end else if (jab_cnt == JAB_LAST) begin
      tx_shutoff_o <= 1'b1; // RULE13
    end else begin
      jab_cnt <= jab_cnt + JW'(1);
    end
  end

  // latched flags, a new event beats the read clear
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      jabber_flag_o <= 1'b0;
      polarity_flag <= 1'b0;
    end else begin
      if (speed100_i) begin
        jabber_flag_o <= 1'b0; // RULE11
      end else if (tx_shutoff_o) begin
        jabber_flag_o <= 1'b1; // RULE10
      end else if (rd_errst || status_mirror_rd_i) begin
        jabber_flag_o <= 1'b0; // RULE10
      end
      if (polarity_event_i) begin
        polarity_flag <= 1'b1; // RULE12
      end else if (rd_errst) begin
        polarity_flag <= 1'b0;
      end
    end
  end

  // crossover selection
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      mdix_sel_o <= 1'b0;
      mdix_auto_en_o <= 1'b0;
    end else begin
      mdix_auto_en_o <= ~fiber_mode_select_i & ~errctl[ERR_MDIX_FORCE] & ~errctl[ERR_AUTO_DIS];
      if (fiber_mode_select_i) begin
        mdix_sel_o <= 1'b0; // RULE7
      end else if (errctl[ERR_MDIX_FORCE]) begin
        mdix_sel_o <= 1'b1; // RULE7
      end else if (!errctl[ERR_AUTO_DIS]) begin
        mdix_sel_o <= auto_mdix_sel_i; // RULE8
      end else begin
        mdix_sel_o <= 1'b0; // RULE9
      end
    end
  end

  // echo blocking on the mac receive side
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      tx_seen <= 1'b0;
      rx_dv_o <= 1'b0;
      crs_o <= 1'b0;
    end else begin
      if (tx_en_i) begin
        tx_seen <= 1'b1;
      end else if (!crs_raw_i) begin
        tx_seen <= 1'b0;
      end
      if (echo_blk && (tx_en_i || tx_seen)) begin
        rx_dv_o <= 1'b0; // RULE3
      end else begin
        rx_dv_o <= rx_dv_raw_i;
      end
      if (echo_blk) begin
        crs_o <= tx_en_i | (crs_raw_i & ~tx_seen); // RULE4
      end else begin
        crs_o <= crs_raw_i;
      end
    end
  end

  // signal quality error control
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      sqe_force_o <= 1'b0;
    end else begin
      sqe_force_o <= ~aux2[AUX2_SQE_CTL] & ten_hd; // RULE5
    end
  end

  property p_echo_rxdv;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (echo_blk && tx_en_i) |=> !rx_dv_o;
  endproperty
  a_echo_rxdv: assert property (p_echo_rxdv) else $error("echo reached rx_dv"); // RULE3

  property p_crs_drop;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (echo_blk && $past(tx_en_i) && !tx_en_i) |=> !crs_o;
  endproperty
  a_crs_drop: assert property (p_crs_drop) else $error("crs lingered after tx_en"); // RULE4

  property p_sqe;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    ##1 sqe_force_o == $past(!aux2[AUX2_SQE_CTL] && ten_hd);
  endproperty
  a_sqe: assert property (p_sqe) else $error("sqe force wrong"); // RULE5

  property p_mdix_read;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    rd_errst |=> rd_data[ERR_MDIX_STATUS] == $past(mdix_sel_o) && rd_data[7:0] == ERRST_RO_LOW;
  endproperty
  a_mdix_read: assert property (p_mdix_read) else $error("status read wrong"); // RULE6

  property p_mdix_force;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (errctl[ERR_MDIX_FORCE] && !fiber_mode_select_i) [*2] |-> mdix_sel_o;
  endproperty
  a_mdix_force: assert property (p_mdix_force) else $error("force not applied"); // RULE7

  property p_mdix_auto;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (!errctl[ERR_MDIX_FORCE] && !errctl[ERR_AUTO_DIS] && !fiber_mode_select_i)
      |=> mdix_sel_o == $past(auto_mdix_sel_i);
  endproperty
  a_mdix_auto: assert property (p_mdix_auto) else $error("auto result lost"); // RULE8

  property p_mdix_off;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (errctl[ERR_AUTO_DIS] && !errctl[ERR_MDIX_FORCE]) |=> !mdix_sel_o && !mdix_auto_en_o;
  endproperty
  a_mdix_off: assert property (p_mdix_off) else $error("auto not disabled"); // RULE9

  property p_jab_hold;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (jabber_flag_o && !rd_errst && !status_mirror_rd_i && !speed100_i) |=> jabber_flag_o;
  endproperty
  a_jab_hold: assert property (p_jab_hold) else $error("jabber flag lost"); // RULE10

  property p_jab_set;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (tx_shutoff_o && !speed100_i) |=> jabber_flag_o;
  endproperty
  a_jab_set: assert property (p_jab_set) else $error("jabber not latched"); // RULE10

  property p_jab_fast;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    speed100_i |=> !jabber_flag_o && !tx_shutoff_o;
  endproperty
  a_jab_fast: assert property (p_jab_fast) else $error("jabber at 100"); // RULE11

  property p_pol;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    polarity_event_i |=> polarity_flag;
  endproperty
  a_pol: assert property (p_pol) else $error("polarity not latched"); // RULE12

  property p_shutoff;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    !tx_en_i |=> !tx_shutoff_o;
  endproperty
  a_shutoff: assert property (p_shutoff) else $error("shutoff without transmit"); // RULE13
endmodule

// >>> test/pamr_mgmt_master.sv
// station management master model for the serial management pins
`timescale 1ns/1ps
module pamr_mgmt_master (
  // clock
  input wire logic ref_clk_i,
  // management pins
  output logic mdc_o,
  output logic mdio_o,
  input wire logic dut_mdio_i,
  input wire logic dut_oe_i
);
  logic drv;
  logic dout;
  // wire level, pull-up when nobody drives
  assign mdio_o = dut_oe_i ? dut_mdio_i : (drv ? dout : 1'b1);
  initial begin
    mdc_o = 1'b0;
    drv = 1'b0;
    dout = 1'b1;
  end
  // one management clock period, line sampled just before the rise
  task automatic bit_cyc(input logic d, input logic en, output logic s);
    @(negedge ref_clk_i);
    drv = en;
    dout = d;
    repeat (3) @(negedge ref_clk_i);
    s = mdio_o;
    mdc_o = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    mdc_o = 1'b0;
  endtask
  // one whole frame; released line during turnaround and data of a read
  task automatic xfer(input logic [4:0] phy, input logic [1:0] op, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic [17:0] dat;
    logic s;
    hdr = {2'h1, op, phy, ra};
    dat = {2'h2, wd};
    rd = 16'h0000;
    for (int i = 0; i < 32; i++) bit_cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_cyc(hdr[i], 1'b1, s);
    for (int i = 17; i >= 0; i--) begin
      bit_cyc(dat[i], op == 2'h1, s);
      if (i < 16) rd[i] = s;
    end
    @(negedge ref_clk_i);
    drv = 1'b0;
    repeat (4) @(negedge ref_clk_i);
  endtask
endmodule

// >>> test/tb.sv
// self-checking testbench for the mode and status register block
`timescale 1ns/1ps
module tb;
  import pamr_pkg::*;
  localparam int unsigned JC = 50;
  localparam int unsigned BC = 8;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic mdc, mdio_line, mdio_q, mdio_oe;
  logic spd100, fdx, fiber, link_up, tx_en, rx_raw, crs_raw, jab_dis, auto_sel;
  logic act, coll, pol_ev, mirror;
  logic rx_dv, crs, tx_off, sqe, mdix_en, mdix_sel, jab_flag, led_link, led_speed, led_act;
  logic [15:0] aux, err;
  logic jab, pol;
  int fail_count = 0;
  int samples_checked = 0;
  int seed = 49;
  int n, nl, na;
  always #25 ref_clk_i = ~ref_clk_i;
  pamr_mgmt_master i_pamr_mgmt_master (.ref_clk_i(ref_clk_i), .mdc_o(mdc),
    .mdio_o(mdio_line), .dut_mdio_i(mdio_q), .dut_oe_i(mdio_oe));
  pamr_mode_status #(.JABBER_CYCLES(JC), .BLINK_CYCLES(BC)) i_pamr_mode_status (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .mdc_i(mdc), .mdio_i(mdio_line),
    .mdio_o(mdio_q), .mdio_oe_o(mdio_oe), .speed100_i(spd100), .full_duplex_i(fdx),
    .fiber_mode_select_i(fiber), .link_up_i(link_up), .tx_en_i(tx_en), .rx_dv_raw_i(rx_raw),
    .crs_raw_i(crs_raw), .rx_dv_o(rx_dv), .crs_o(crs), .jabber_disable_i(jab_dis),
    .tx_shutoff_o(tx_off), .sqe_force_o(sqe), .auto_mdix_sel_i(auto_sel),
    .mdix_auto_en_o(mdix_en), .mdix_sel_o(mdix_sel), .activity_i(act), .collision_i(coll),
    .polarity_event_i(pol_ev), .status_mirror_rd_i(mirror), .jabber_flag_o(jab_flag),
    .led_link_o(led_link), .led_speed_o(led_speed), .led_act_o(led_act));
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk_reg(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pin(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge ref_clk_i);
  endtask
  function automatic logic [15:0] exp_err();
    logic m;
    m = fiber ? 1'b0 : (err[12] ? 1'b1 : (!err[11] ? auto_sel : 1'b0));
    return err | {2'h0, m, 3'h0, jab, pol, ERRST_RO_LOW};
  endfunction
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] r;
    i_pamr_mgmt_master.xfer(PHY_ADDR_DEF, MDIO_OP_WRITE, a, d, r);
    if (a == REG_AUX_MODE_TWO) aux = (aux & ~AUX2_WMASK) | (d & AUX2_WMASK);
    if (a == REG_ERR_GEN_STATUS) err = (err & ~ERRST_WMASK) | (d & ERRST_WMASK);
  endtask
  task automatic rd(input logic [4:0] a, input string nm);
    logic [15:0] r;
    logic [15:0] e;
    e = (a == REG_AUX_MODE_TWO) ? aux : ((a == REG_ERR_GEN_STATUS) ? exp_err() : 16'h0000);
    i_pamr_mgmt_master.xfer(PHY_ADDR_DEF, MDIO_OP_READ, a, 16'h0000, r);
    chk_reg(nm, e, r);
    if (a == REG_ERR_GEN_STATUS) begin
      pol = 1'b0;
      if (!tx_en) jab = 1'b0;
    end
  endtask
  // pulse activity or collision, count lit cycles of link and act
  task automatic blink(input logic which);
    act = !which;
    coll = which;
    tick(1);
    act = 1'b0;
    coll = 1'b0;
    nl = 0;
    na = 0;
    for (int i = 0; i < 3 * BC; i++) begin
      tick(1);
      nl += int'(led_link === 1'b1);
      na += int'(led_act === 1'b1);
    end
  endtask
  initial begin
    {spd100, fdx, fiber, link_up, tx_en, rx_raw, crs_raw, jab_dis, auto_sel} = '0;
    {act, coll, pol_ev, mirror} = '0;
    aux = AUX2_RESET;
    err = ERRST_RESET;
    jab = 1'b0;
    pol = 1'b0;
    tick(10);
    resetn_i = 1'b1;
    tick(2);
    chk_pin("mdix_auto_en", 1'b0, mdix_en);
    chk_pin("sqe_force", 1'b0, sqe);
    rd(REG_AUX_MODE_TWO, "aux2");
    rd(REG_ERR_GEN_STATUS, "errst");
    rd(5'h05, "unmapped");
    for (int i = 0; i < 4; i++) begin
      wr(REG_AUX_MODE_TWO, 16'($random(seed)));
      rd(REG_AUX_MODE_TWO, "aux2");
      wr(REG_ERR_GEN_STATUS, 16'($random(seed)));
      rd(REG_ERR_GEN_STATUS, "errst");
    end
    wr(REG_ERR_GEN_STATUS, ERRST_RESET);
    $display("done: registers");
    wr(REG_AUX_MODE_TWO, AUX2_RESET & ~16'h0008);
    tick(2);
    chk_pin("sqe_force", 1'b1, sqe);
    fdx = 1'b1;
    tick(2);
    chk_pin("sqe_force", 1'b0, sqe);
    fdx = 1'b0;
    wr(REG_AUX_MODE_TWO, AUX2_RESET | 16'h0080);
    {tx_en, rx_raw, crs_raw} = 3'h7;
    tick(3);
    chk_pin("rx_dv", 1'b0, rx_dv);
    chk_pin("crs", 1'b1, crs);
    tx_en = 1'b0;
    tick(1);
    chk_pin("crs", 1'b0, crs);
    chk_pin("rx_dv", 1'b0, rx_dv);
    {rx_raw, crs_raw} = 2'h0;
    wr(REG_AUX_MODE_TWO, AUX2_RESET);
    {tx_en, rx_raw, crs_raw} = 3'h7;
    tick(2);
    chk_pin("rx_dv", 1'b1, rx_dv);
    {tx_en, rx_raw, crs_raw} = 3'h0;
    $display("done: echo and sqe");
    auto_sel = 1'($random(seed));
    wr(REG_ERR_GEN_STATUS, 16'h1800);
    tick(2);
    chk_pin("mdix_sel", 1'b1, mdix_sel);
    rd(REG_ERR_GEN_STATUS, "errst");
    fiber = 1'b1;
    tick(2);
    chk_pin("mdix_sel", 1'b0, mdix_sel);
    rd(REG_ERR_GEN_STATUS, "errst");
    fiber = 1'b0;
    wr(REG_ERR_GEN_STATUS, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      auto_sel = k[0];
      tick(2);
      chk_pin("mdix_auto_en", 1'b1, mdix_en);
      chk_pin("mdix_sel", k[0], mdix_sel);
      rd(REG_ERR_GEN_STATUS, "errst");
    end
    wr(REG_ERR_GEN_STATUS, ERRST_RESET);
    $display("done: crossover");
    tx_en = 1'b1;
    n = 0;
    while (tx_off !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    chk_reg("jabber_time", 16'(JC), 16'(n));
    jab = 1'b1;
    tick(2);
    chk_pin("jabber_flag", 1'b1, jab_flag);
    rd(REG_ERR_GEN_STATUS, "errst");
    chk_pin("jabber_flag", 1'b1, jab_flag);
    tx_en = 1'b0;
    tick(2);
    chk_pin("tx_shutoff", 1'b0, tx_off);
    rd(REG_ERR_GEN_STATUS, "errst");
    rd(REG_ERR_GEN_STATUS, "errst");
    tx_en = 1'b1;
    tick(JC + 5);
    tx_en = 1'b0;
    tick(2);
    chk_pin("jabber_flag", 1'b1, jab_flag);
    mirror = 1'b1;
    tick(1);
    mirror = 1'b0;
    tick(2);
    chk_pin("jabber_flag", 1'b0, jab_flag);
    tx_en = 1'b1;
    tick(JC + 5);
    spd100 = 1'b1;
    tick(2);
    chk_pin("jabber_flag", 1'b0, jab_flag);
    chk_pin("tx_shutoff", 1'b0, tx_off);
    tx_en = 1'b0;
    pol_ev = 1'b1;
    tick(1);
    pol_ev = 1'b0;
    tick(2);
    pol = 1'b1;
    spd100 = 1'b0;
    rd(REG_ERR_GEN_STATUS, "errst");
    rd(REG_ERR_GEN_STATUS, "errst");
    // jabber timer switched off: long transmit must not trip it
    jab_dis = 1'b1;
    tx_en = 1'b1;
    tick(JC + 5);
    chk_pin("tx_shutoff", 1'b0, tx_off);
    chk_pin("jabber_flag", 1'b0, jab_flag);
    {tx_en, jab_dis} = 2'h0;
    tick(2);
    $display("done: jabber and polarity");
    {spd100, link_up} = 2'b11;
    tick(2);
    chk_pin("led_speed", 1'b1, led_speed);
    spd100 = 1'b0;
    tick(2);
    chk_pin("led_speed", 1'b0, led_speed);
    blink(1'b0);
    chk_reg("act_lit", 16'(BC / 2), 16'(na));
    chk_reg("link_lit", 16'(3 * BC), 16'(nl));
    wr(REG_AUX_MODE_TWO, AUX2_RESET | 16'h0200);
    blink(1'b0);
    chk_reg("link_lit", 16'(3 * BC - BC / 2), 16'(nl));
    blink(1'b1);
    chk_reg("act_lit", 16'(BC / 2), 16'(na));
    fdx = 1'b1;
    blink(1'b1);
    chk_reg("act_lit", 16'(3 * BC - BC / 2), 16'(na));
    $display("done: indicators");
    report_and_stop();
  end
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    fail_count++;
    $display("timeout");
    report_and_stop();
  end
endmodule
